// ### rtl/rhl_defines.svh
/*
 Shared constants for the radio host link: timing counts, frame size, reset
 levels of the host control outputs.
 Assumes a 10 MHz system clock on both ends.
*/
`ifndef RHL_DEFINES_SVH
`define RHL_DEFINES_SVH

// ==========================================================
// Clock rates
`define RHL_SYS_CLK_HZ 10000000
`define RHL_SYS_CLK_NS 100
`define RHL_SLOW_CLK_HZ 32768
// Slow clock half period in system cycles
`define RHL_SLOW_HALF_CYC (`RHL_SYS_CLK_HZ / (2 * `RHL_SLOW_CLK_HZ))

// ==========================================================
// Serial link timing
`define RHL_SCK_HALF_NS 400
`define RHL_SCK_HALF_CYC (`RHL_SCK_HALF_NS / `RHL_SYS_CLK_NS)
`define RHL_FRAME_BITS 8

// ==========================================================
// Radio clock output half periods, scaled to the system clock
`define RHL_CLKO_HALF_16M 1
`define RHL_CLKO_HALF_8M 2
`define RHL_CLKO_HALF_4M 4

// ==========================================================
// Reset levels of host controls
`define RHL_PWR_RST 1'h0
`define RHL_BB_RST_N_RST 1'h0
`define RHL_CE_RST 1'h0
`define RHL_SEL_N_RST 1'h1
`define RHL_SCK_IDLE 1'h1

`endif

// ### rtl/rhl_pkg.sv
/*
 Types for the radio host link.
 Assumes rhl_defines.svh for all numeric constants.
*/
package rhl_pkg;
   // ==========================================================
   // Types
   typedef logic [7:0] rhl_byte_t;
   typedef logic [3:0] rhl_bitcnt_t;
   // Radio clock output rate; code 2'h3 is illegal
   typedef enum logic [1:0] {
      rhl_clko_16m = 2'h0,
      rhl_clko_8m = 2'h1,
      rhl_clko_4m = 2'h2
   } rhl_clko_sel_t;
   // Host serial master states, Gray along the byte path
   typedef enum logic [1:0] {
      rhl_h_idle = 2'h0,
      rhl_h_lead = 2'h1,
      rhl_h_low = 2'h3,
      rhl_h_high = 2'h2
   } rhl_host_state_t;
endpackage : rhl_pkg

// ### rtl/rhl_link_if.sv
/*
 Wires between the host controller and the radio unit.
 Assumes each end drives only the signals of its own modport.
*/
`timescale 1ns/1ns
interface rhl_link_if;
   logic radio_power_enable;
   logic radio_baseband_rst_n;
   logic radio_chip_enable;
   logic radio_link_select_n;
   logic buck_converter_bypass;
   logic slow_clock_external_select;
   logic radio_serial_clock_in;
   logic radio_serial_in;
   logic radio_serial_out;
   logic radio_irq_out;
   logic radio_slow_clock_in;

   // Host end drives controls, clock and its data line
   modport host (
      output radio_power_enable,
      output radio_baseband_rst_n,
      output radio_chip_enable,
      output radio_link_select_n,
      output buck_converter_bypass,
      output slow_clock_external_select,
      output radio_serial_clock_in,
      output radio_serial_in,
      output radio_slow_clock_in,
      input radio_serial_out,
      input radio_irq_out
   );
   // Radio end answers with data and interrupt status
   modport radio (
      input radio_power_enable,
      input radio_baseband_rst_n,
      input radio_chip_enable,
      input radio_link_select_n,
      input buck_converter_bypass,
      input slow_clock_external_select,
      input radio_serial_clock_in,
      input radio_serial_in,
      input radio_slow_clock_in,
      output radio_serial_out,
      output radio_irq_out
   );
endinterface : rhl_link_if

// ### rtl/rhl_sync2.sv
/*
 Two flip-flop synchroniser for a group of level signals.
 Assumes each bit is independent; no word coherence.
*/
`timescale 1ns/1ns
module rhl_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule : rhl_sync2

// ### rtl/rhl_radio_end.sv
/*
 Radio unit end of the host link: power, reset and enable gating, serial
 slave, interrupt status output, slow clock source and clock output.
 Assumes every link input is asynchronous to sys_clk_i and that the host
 keeps the serial clock half period at four system cycles or more.
*/
`timescale 1ns/1ns
`include "rhl_defines.svh"

// Behaviour
// - Baseband held in reset while reset low
// - Unit enabled only while chip enable high
// - Host sources the dedicated serial clock
// - Full duplex: each side drives other's input
// - Serial accepted only while select is low
// - Buck converter used while bypass is low
// - Slow clock internal when low, pin when high
// - Interrupt status presented on interrupt output
// - Nothing works while power enable low
// - Host raises power enable from low
// - Host feeds slow clock when pin selected
// - Clock output selectable 16, 8, 4 MHz; divider gives 5, 2.5, 1.25 MHz from the 10 MHz system clock
// - Host master, 8-bit frames, MSB first
module rhl_radio_end (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Link toward host
   rhl_link_if.radio link,
   // Reply data from radio core
   input wire rhl_pkg::rhl_byte_t tx_data_i,
   input wire logic tx_load_i,
   // Interrupt sources
   input wire logic irq_src_i,
   input wire logic irq_clr_i,
   // Clock output rate
   input wire rhl_pkg::rhl_clko_sel_t clko_sel_i,
   // Received data
   output rhl_pkg::rhl_byte_t rx_data_o,
   output logic rx_valid_o,
   // Status
   output logic irq_pend_o,
   output logic powered_o,
   output logic active_o,
   output logic buck_in_use_o,
   output logic slow_ext_o,
   output logic slow_tick_o,
   output logic clk_out_o
);
   import rhl_pkg::*;

   // ==========================================================
   // Input synchronisation
   logic [8:0] raw_in;
   logic [8:0] syn_in;
   logic s_pe;
   logic s_rst_n;
   logic s_ce;
   logic s_sel_n;
   logic s_bypass;
   logic s_ext;
   logic s_sck;
   logic s_mosi;
   logic s_slow;

   // All link inputs as one group
   assign raw_in = {link.radio_power_enable, link.radio_baseband_rst_n,
                    link.radio_chip_enable, link.radio_link_select_n,
                    link.buck_converter_bypass,
                    link.slow_clock_external_select,
                    link.radio_serial_clock_in, link.radio_serial_in,
                    link.radio_slow_clock_in};

   rhl_sync2 #(
      .WIDTH(9)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(raw_in),
      .q_o(syn_in)
   );

   // Named views of the synchronised group
   assign {s_pe, s_rst_n, s_ce, s_sel_n, s_bypass, s_ext, s_sck, s_mosi,
           s_slow} = syn_in;

   // ==========================================================
   // Power, reset and enable gating
   logic run;
   logic en;
   logic link_on;

   assign run = s_pe & s_rst_n;
   assign en = run & s_ce;
   assign link_on = en & ~s_sel_n;

   // ==========================================================
   // Edge detection on synchronised levels
   logic sck_d_r;
   logic slow_d_r;
   logic on_d_r;
   logic sck_rise;
   logic sck_fall;

   // Previous samples of clocks and link state
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sck_d_r <= `RHL_SCK_IDLE;
         slow_d_r <= 1'h0;
         on_d_r <= 1'h0;
      end else begin
         sck_d_r <= s_sck;
         slow_d_r <= s_slow;
         on_d_r <= link_on;
      end
   end

   assign sck_rise = s_sck & ~sck_d_r;
   assign sck_fall = ~s_sck & sck_d_r;

   // ==========================================================
   // Serial slave
   rhl_byte_t tx_hold_r;
   rhl_byte_t tx_sh_r;
   rhl_byte_t rx_sh_r;
   rhl_bitcnt_t bit_cnt_r;
   logic miso_r;

   // Reply byte staging, lost when the baseband is reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_hold_r <= 8'h00;
      end else if (!run) begin
         tx_hold_r <= 8'h00;
      end else if (tx_load_i) begin
         tx_hold_r <= tx_data_i;
      end
   end

   // Shift in on rising, out on falling, MSB first
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         miso_r <= 1'h0;
         rx_data_o <= 8'h00;
         rx_valid_o <= 1'h0;
      end else begin
         rx_valid_o <= 1'h0;
         if (!link_on) begin
            bit_cnt_r <= 4'h0;
            tx_sh_r <= tx_hold_r;
            miso_r <= 1'h0;
            if (!run) begin
               rx_data_o <= 8'h00;
            end
         end else if (!on_d_r) begin
            tx_sh_r <= tx_hold_r;
            miso_r <= tx_hold_r[7];
            bit_cnt_r <= 4'h0;
         end else if (sck_rise) begin
            rx_sh_r <= {rx_sh_r[6:0], s_mosi};
            if (bit_cnt_r == 4'(`RHL_FRAME_BITS - 1)) begin
               rx_data_o <= {rx_sh_r[6:0], s_mosi};
               rx_valid_o <= 1'h1;
               tx_sh_r <= tx_hold_r;
               bit_cnt_r <= 4'h0;
            end else begin
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end
         end else if (sck_fall) begin
            if (bit_cnt_r == 4'h0) begin
               miso_r <= tx_sh_r[7];
            end else begin
               tx_sh_r <= {tx_sh_r[6:0], 1'h0};
               miso_r <= tx_sh_r[6];
            end
         end
      end
   end

   assign link.radio_serial_out = miso_r;

   // ==========================================================
   // Interrupt status
   logic irq_out_r;

   // Sticky pending flag, a new source beats a clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_pend_o <= 1'h0;
      end else if (!run) begin
         irq_pend_o <= 1'h0;
      end else if (irq_src_i) begin
         irq_pend_o <= 1'h1;
      end else if (irq_clr_i) begin
         irq_pend_o <= 1'h0;
      end
   end

   // Pending status shown while the unit is enabled
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_out_r <= 1'h0;
      end else begin
         irq_out_r <= irq_pend_o & en;
      end
   end

   assign link.radio_irq_out = irq_out_r;

   // ==========================================================
   // Slow clock source
   logic [7:0] osc_cnt_r;
   logic osc_r;

   // On-chip slow oscillator model, runs while powered and the internal source is chosen
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_cnt_r <= 8'h00;
         osc_r <= 1'h0;
      end else if (!s_pe || s_ext) begin
         osc_cnt_r <= 8'h00;
         osc_r <= 1'h0;
      end else if (osc_cnt_r == 8'(`RHL_SLOW_HALF_CYC - 1)) begin
         osc_cnt_r <= 8'h00;
         osc_r <= ~osc_r;
      end else begin
         osc_cnt_r <= osc_cnt_r + 8'h01;
      end
   end

   // One tick per rising edge of the chosen source
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slow_tick_o <= 1'h0;
      end else if (!s_pe) begin
         slow_tick_o <= 1'h0;
      end else if (s_ext) begin
         slow_tick_o <= s_slow & ~slow_d_r;
      end else begin
         slow_tick_o <= (osc_cnt_r == 8'(`RHL_SLOW_HALF_CYC - 1)) & ~osc_r;
      end
   end

   // ==========================================================
   // Clock output divider
   logic [2:0] clko_cnt_r;
   logic [2:0] clko_half;

   // Half period for the selected rate
   always_comb begin
      unique case (clko_sel_i)
         rhl_clko_16m: clko_half = 3'(`RHL_CLKO_HALF_16M);
         rhl_clko_8m: clko_half = 3'(`RHL_CLKO_HALF_8M);
         rhl_clko_4m: clko_half = 3'(`RHL_CLKO_HALF_4M);
         default: clko_half = 3'h0;
      endcase
   end

   // Toggle on half period, stopped when disabled or code illegal
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clko_cnt_r <= 3'h0;
         clk_out_o <= 1'h0;
      end else if (!en || clko_half == 3'h0) begin
         clko_cnt_r <= 3'h0;
         clk_out_o <= 1'h0;
      end else if (clko_cnt_r == clko_half - 3'h1) begin
         clko_cnt_r <= 3'h0;
         clk_out_o <= ~clk_out_o;
      end else begin
         clko_cnt_r <= clko_cnt_r + 3'h1;
      end
   end

   // ==========================================================
   // Status levels
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         powered_o <= 1'h0;
         active_o <= 1'h0;
         buck_in_use_o <= 1'h0;
         slow_ext_o <= 1'h0;
      end else begin
         powered_o <= s_pe;
         active_o <= en;
         buck_in_use_o <= s_pe & ~s_bypass;
         slow_ext_o <= s_pe & s_ext;
      end
   end
endmodule : rhl_radio_end

// ### rtl/rhl_host_end.sv
/*
 Host end of the radio link: control outputs, serial master, slow clock
 feed and interrupt input.
 Assumes user-side inputs come from logic on sys_clk_i.
*/
`timescale 1ns/1ns
`include "rhl_defines.svh"

module rhl_host_end (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Link toward radio
   rhl_link_if.host link,
   // Control levels
   input wire logic power_en_i,
   input wire logic bb_release_i,
   input wire logic chip_en_i,
   input wire logic buck_bypass_i,
   input wire logic slow_ext_i,
   // Transfer request
   input wire logic xfer_valid_i,
   input wire rhl_pkg::rhl_byte_t xfer_data_i,
   input wire logic xfer_last_i,
   output logic xfer_ready_o,
   // Received byte and interrupt
   output rhl_pkg::rhl_byte_t rd_data_o,
   output logic rd_valid_o,
   output logic host_irq_o
);
   import rhl_pkg::*;

   // ==========================================================
   // Control ports
   logic host_port_power_enable_r;
   logic host_port_radio_reset_r;
   logic host_port_chip_enable_r;
   logic host_port_buck_bypass_r;
   logic host_port_slow_clock_sel_r;
   logic link_ok;

   // Power first, reset released only once powered
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_port_power_enable_r <= `RHL_PWR_RST;
         host_port_radio_reset_r <= `RHL_BB_RST_N_RST;
         host_port_chip_enable_r <= `RHL_CE_RST;
         host_port_buck_bypass_r <= 1'h0;
         host_port_slow_clock_sel_r <= 1'h0;
      end else begin
         host_port_power_enable_r <= power_en_i;
         host_port_radio_reset_r <= power_en_i & host_port_power_enable_r & bb_release_i;
         host_port_chip_enable_r <= chip_en_i;
         host_port_buck_bypass_r <= buck_bypass_i;
         host_port_slow_clock_sel_r <= slow_ext_i;
      end
   end

   assign link_ok = host_port_power_enable_r & host_port_radio_reset_r & host_port_chip_enable_r;
   assign link.radio_power_enable = host_port_power_enable_r;
   assign link.radio_baseband_rst_n = host_port_radio_reset_r;
   assign link.radio_chip_enable = host_port_chip_enable_r;
   assign link.buck_converter_bypass = host_port_buck_bypass_r;
   assign link.slow_clock_external_select = host_port_slow_clock_sel_r;

   // ==========================================================
   // Radio inputs through synchroniser
   logic [1:0] syn_in;
   logic s_miso;

   rhl_sync2 #(
      .WIDTH(2)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .d_i({link.radio_serial_out, link.radio_irq_out}),
      .q_o(syn_in)
   );

   assign s_miso = syn_in[1];

   // Interrupt status registered out
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_irq_o <= 1'h0;
      end else begin
         host_irq_o <= syn_in[0];
      end
   end

   // ==========================================================
   // Serial master
   rhl_host_state_t state_r;
   logic [3:0] half_cnt_r;
   rhl_bitcnt_t bit_cnt_r;
   rhl_byte_t tx_sh_r;
   rhl_byte_t rx_sh_r;
   logic last_r;
   logic host_serial_clock_out_r;
   logic host_serial_out_r;
   logic host_port_link_select_r;
   logic half_done;
   logic take;

   assign half_done = (half_cnt_r == 4'(`RHL_SCK_HALF_CYC - 1));
   assign take = xfer_ready_o & xfer_valid_i & link_ok;

   // Byte engine, clock idles high, first falling edge shifts nothing
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= rhl_h_idle;
         half_cnt_r <= 4'h0;
         bit_cnt_r <= 4'h0;
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         last_r <= 1'h0;
         host_serial_clock_out_r <= `RHL_SCK_IDLE;
         host_serial_out_r <= 1'h0;
         host_port_link_select_r <= `RHL_SEL_N_RST;
         xfer_ready_o <= 1'h0;
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'h0;
      end else begin
         rd_valid_o <= 1'h0;
         half_cnt_r <= half_done ? 4'h0 : half_cnt_r + 4'h1;
         unique case (state_r)
            rhl_h_idle: begin
               half_cnt_r <= 4'h0;
               xfer_ready_o <= link_ok & ~take;
               if (take) begin
                  tx_sh_r <= xfer_data_i;
                  host_serial_out_r <= xfer_data_i[7];
                  host_port_link_select_r <= 1'h0;
                  last_r <= xfer_last_i;
                  bit_cnt_r <= 4'h0;
                  state_r <= rhl_h_lead;
               end else if (!link_ok) begin
                  host_port_link_select_r <= 1'h1;
               end
            end
            rhl_h_lead: begin
               if (half_done) begin
                  host_serial_clock_out_r <= 1'h0;
                  state_r <= rhl_h_low;
               end
            end
            rhl_h_low: begin
               if (half_done) begin
                  host_serial_clock_out_r <= 1'h1;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  state_r <= rhl_h_high;
               end
            end
            rhl_h_high: begin
               if (half_done) begin
                  rx_sh_r <= {rx_sh_r[6:0], s_miso};
                  if (bit_cnt_r == 4'(`RHL_FRAME_BITS)) begin
                     rd_data_o <= {rx_sh_r[6:0], s_miso};
                     rd_valid_o <= 1'h1;
                     host_port_link_select_r <= ~link_ok | last_r;
                     xfer_ready_o <= link_ok;
                     state_r <= rhl_h_idle;
                  end else begin
                     host_serial_clock_out_r <= 1'h0;
                     tx_sh_r <= {tx_sh_r[6:0], 1'h0};
                     host_serial_out_r <= tx_sh_r[6];
                     state_r <= rhl_h_low;
                  end
               end
            end
         endcase
      end
   end

   assign link.radio_serial_clock_in = host_serial_clock_out_r;
   assign link.radio_serial_in = host_serial_out_r;
   assign link.radio_link_select_n = host_port_link_select_r;

   // ==========================================================
   // Slow clock feed
   logic [7:0] slow_cnt_r;
   logic host_clock_output_r;

   // Divider runs only while the radio takes its slow clock from the pin
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slow_cnt_r <= 8'h00;
         host_clock_output_r <= 1'h0;
      end else if (!host_port_slow_clock_sel_r) begin
         slow_cnt_r <= 8'h00;
         host_clock_output_r <= 1'h0;
      end else if (slow_cnt_r == 8'(`RHL_SLOW_HALF_CYC - 1)) begin
         slow_cnt_r <= 8'h00;
         host_clock_output_r <= ~host_clock_output_r;
      end else begin
         slow_cnt_r <= slow_cnt_r + 8'h01;
      end
   end

   assign link.radio_slow_clock_in = host_clock_output_r;
endmodule : rhl_host_end

// ### testbench/rhl_link_properties.sv
/*
 Concurrent checks on the wires between host end and radio end.
 Assumes one sys_clk_i domain and an active low asynchronous reset.
*/
`timescale 1ns/1ns
module rhl_link_properties (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Link wires
   input wire logic radio_power_enable,
   input wire logic radio_baseband_rst_n,
   input wire logic radio_chip_enable,
   input wire logic radio_link_select_n,
   input wire logic buck_converter_bypass,
   input wire logic slow_clock_external_select,
   input wire logic radio_serial_clock_in,
   input wire logic radio_serial_in,
   input wire logic radio_serial_out,
   input wire logic radio_irq_out,
   input wire logic radio_slow_clock_in
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Frames only while fully enabled
   sel_needs_enable_a: assert property (!radio_link_select_n |-> radio_power_enable &&
      radio_baseband_rst_n && radio_chip_enable) else $error("select low while disabled");
   // Serial clock idles high
   sck_idle_high_a: assert property (radio_link_select_n |-> radio_serial_clock_in)
      else $error("serial clock low outside frame");
   // Baseband release only after power is up
   bb_after_power_a: assert property ($rose(radio_baseband_rst_n) |-> $past(radio_power_enable))
      else $error("baseband released before power");
   // Radio data line quiet when not selected
   miso_idle_a: assert property (radio_link_select_n [*5] |-> !radio_serial_out)
      else $error("data while deselected");
   // Low phase lasts four cycles
   sck_low_phase_a: assert property ($fell(radio_serial_clock_in) |-> !radio_serial_clock_in [*4]
      ##1 radio_serial_clock_in) else $error("bad low phase");
   // High phase lasts at least four cycles
   sck_high_phase_a: assert property ($rose(radio_serial_clock_in) |-> radio_serial_clock_in [*4])
      else $error("serial clock high phase too short");
   // Host data stable around the sampling edge
   mosi_stable_a: assert property ($rose(radio_serial_clock_in) |-> $stable(radio_serial_in) [*4])
      else $error("data moved in high phase");
   // No slow clock fed when on-chip source chosen
   slow_off_a: assert property (!slow_clock_external_select [*3] |-> !radio_slow_clock_in)
      else $error("slow clock fed while internal");

   // ==========================================================
   // Coverage
   frame_c: cover property ($fell(radio_link_select_n));
   irq_c: cover property ($rose(radio_irq_out));
   slow_c: cover property ($rose(radio_slow_clock_in));
   bypass_c: cover property ($rose(buck_converter_bypass));
endmodule : rhl_link_properties

// ### testbench/tb_top.sv
/*
 Self-checking bench joining both link ends.
 Assumes 10 MHz clock shared by both ends and one common reset.
*/
`timescale 1ns/1ns
module tb_top;
   import rhl_pkg::*;
   // ==========================================================
   // Signals
   logic sys_clk_i = 1'h0, rst_n_i = 1'h0;
   logic power_en_i = 1'h0, bb_release_i = 1'h0, chip_en_i = 1'h0;
   logic buck_bypass_i = 1'h0, slow_ext_i = 1'h0, xfer_valid_i = 1'h0, xfer_last_i = 1'h0;
   rhl_byte_t xfer_data_i = 8'h00, tx_data_i = 8'h00, rd_data_o, rx_data_o, wire_byte, rx_seen;
   logic tx_load_i = 1'h0, irq_src_i = 1'h0, irq_clr_i = 1'h0;
   rhl_clko_sel_t clko_sel_i = rhl_clko_16m;
   logic xfer_ready_o, rd_valid_o, host_irq_o, rx_valid_o, irq_pend_o, powered_o, active_o;
   logic buck_in_use_o, slow_ext_o, slow_tick_o, clk_out_o;
   int miscompares = 0, cmp_count = 0;

   // ==========================================================
   // Ends, link and checker
   rhl_link_if rhl_link_if_inst ();
   rhl_host_end rhl_host_end_inst (.link(rhl_link_if_inst), .*);
   rhl_radio_end rhl_radio_end_inst (.link(rhl_link_if_inst), .*);
   rhl_link_properties rhl_link_properties_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .radio_power_enable(rhl_link_if_inst.radio_power_enable),
      .radio_baseband_rst_n(rhl_link_if_inst.radio_baseband_rst_n),
      .radio_chip_enable(rhl_link_if_inst.radio_chip_enable),
      .radio_link_select_n(rhl_link_if_inst.radio_link_select_n),
      .buck_converter_bypass(rhl_link_if_inst.buck_converter_bypass),
      .slow_clock_external_select(rhl_link_if_inst.slow_clock_external_select),
      .radio_serial_clock_in(rhl_link_if_inst.radio_serial_clock_in),
      .radio_serial_in(rhl_link_if_inst.radio_serial_in),
      .radio_serial_out(rhl_link_if_inst.radio_serial_out),
      .radio_irq_out(rhl_link_if_inst.radio_irq_out),
      .radio_slow_clock_in(rhl_link_if_inst.radio_slow_clock_in));

   // Capture of wire and receive data
   always @(posedge rhl_link_if_inst.radio_serial_clock_in) begin
      if (!rhl_link_if_inst.radio_link_select_n) wire_byte <= {wire_byte[6:0], rhl_link_if_inst.radio_serial_in};
   end
   always @(posedge sys_clk_i) begin
      if (rx_valid_o === 1'h1) rx_seen <= rx_data_o;
   end

   // ==========================================================
   // Helpers
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'h1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : cyc
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // Scenarios
   task automatic t_power;
      xfer_valid_i <= 1'h1;
      power_en_i <= 1'h1;
      cyc(10);
      chk(rhl_link_if_inst.radio_baseband_rst_n === 1'h0 && active_o === 1'h0, "baseband out of reset");
      bb_release_i <= 1'h1;
      cyc(10);
      chk(powered_o === 1'h1 && active_o === 1'h0, "active without chip enable");
      chk(xfer_ready_o === 1'h0 && rhl_link_if_inst.radio_link_select_n === 1'h1, "take before enable");
      xfer_valid_i <= 1'h0;
      chip_en_i <= 1'h1;
      cyc(10);
      chk(active_o === 1'h1 && xfer_ready_o === 1'h1, "not ready when enabled");
   endtask : t_power
   task automatic t_byte(input rhl_byte_t d, input logic last, input rhl_byte_t reply);
      int n = 0;
      xfer_valid_i <= 1'h1;
      xfer_data_i <= d;
      xfer_last_i <= last;
      do cyc(1); while (xfer_ready_o !== 1'h1 && ++n < 200);
      xfer_valid_i <= 1'h0;
      n = 0;
      do cyc(1); while (rd_valid_o !== 1'h1 && ++n < 200);
      chk(rd_data_o === reply && n < 200, "reply byte wrong");
      chk(wire_byte === d && rx_seen === d, "sent byte wrong");
      chk(rhl_link_if_inst.radio_link_select_n === last, "select framing wrong");
   endtask : t_byte
   task automatic t_load(input rhl_byte_t r);
      tx_data_i <= r;
      tx_load_i <= 1'h1;
      cyc(1);
      tx_load_i <= 1'h0;
      cyc(2);
   endtask : t_load
   task automatic t_irq;
      int n = 0;
      irq_src_i <= 1'h1;
      cyc(1);
      irq_src_i <= 1'h0;
      do cyc(1); while (host_irq_o !== 1'h1 && ++n < 20);
      chk(n < 20 && irq_pend_o === 1'h1, "interrupt not seen");
      irq_clr_i <= 1'h1;
      cyc(1);
      irq_clr_i <= 1'h0;
      cyc(10);
      chk(host_irq_o === 1'h0 && rhl_link_if_inst.radio_irq_out === 1'h0, "interrupt not cleared");
   endtask : t_irq
   task automatic t_modes;
      int n = 0;
      buck_bypass_i <= 1'h1;
      slow_ext_i <= 1'h1;
      cyc(6);
      chk(buck_in_use_o === 1'h0 && slow_ext_o === 1'h1, "pin choice wrong");
      do cyc(1); while (slow_tick_o !== 1'h1 && ++n < 700);
      chk(n < 700, "no slow tick from pin");
      buck_bypass_i <= 1'h0;
      slow_ext_i <= 1'h0;
      cyc(6);
      chk(buck_in_use_o === 1'h1 && slow_ext_o === 1'h0, "source choice wrong");
   endtask : t_modes
   task automatic t_clko;
      int n;
      logic v;
      for (int s = 0; s < 3; s++) begin
         clko_sel_i <= rhl_clko_sel_t'(s);
         cyc(12);
         v = clk_out_o;
         do cyc(1); while (clk_out_o === v && ++n < 20);
         v = clk_out_o;
         n = 0;
         do begin cyc(1); n++; end while (clk_out_o === v && n < 20);
         chk(n === (1 << s), "clock output rate wrong");
      end
      clko_sel_i <= rhl_clko_sel_t'(2'h3);
      cyc(4);
      chk(clk_out_o === 1'h0, "illegal rate runs");
   endtask : t_clko

   // ==========================================================
   // Clock, main sequence, watchdog
   initial forever #50 sys_clk_i = ~sys_clk_i;
   initial begin
      cyc(3);
      rst_n_i <= 1'h1;
      cyc(2);
      t_power();
      t_load(8'hA5);
      t_byte(8'h3C, 1'h0, 8'hA5);
      t_byte(8'hC3, 1'h1, 8'hA5);
      t_load(8'h5A);
      t_byte(8'hFF, 1'h1, 8'h5A);
      t_irq();
      t_modes();
      t_clko();
      final_report();
   end
   initial begin
      #2000000;
      miscompares++;
      final_report();
   end
endmodule : tb_top
